// [test/tb_twowire_slave_rx_states.sv]
/*
 * Testbench for the slave receiver status sequence and bus error recovery.
 * Assumes the design package and the bit-level master model.
 */
`timescale 1ns/1ns
module tb_twowire_slave_rx_states
    import tws_pkg::*;
;
    logic ref_clk, srst, reg_wr, reg_rd, arb_lost, ack;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda, hang;
    wire scl_i = m_scl & (scl_oe_n | scl_o);
    wire sda_i = m_sda & (sda_oe_n | sda_o);
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'hD6836815;
    logic [6:0] own;
    logic [7:0] rst_addr [6] = '{OFS_BITRATE, OFS_STATUS, OFS_ADDR, OFS_DATA, OFS_CTRL, 8'h10};
    logic [7:0] rst_val [6] = '{RST_BITRATE, ST_NONE, RST_ADDR, RST_DATA, 8'h00, 8'h00};

    tws_slave_rx DUT (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arb_lost(arb_lost), .scl_i(scl_i),
        .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    tws_master_model u_mst (.scl(scl_i), .sda(sda_i), .m_scl(m_scl), .m_sda(m_sda), .hang(hang));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // step: 0 address, 1 acked data, 2 nacked data, 3 address after lost arbitration
    function automatic logic [7:0] rx_code(input logic bc, input int step);
        logic [7:0] t [4] = '{8'h60, 8'h80, 8'h88, 8'h68};
        return t[step] + (bc ? 8'h10 : 8'h00);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= dat;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    // poll the step flag, then compare the masked status code
    task automatic expect_code(input logic [7:0] code);
        int i;
        v = 8'h00;
        for (i = 0; i < 3000 && v[CB_FLAG] !== 1'b1; i++) rd(OFS_CTRL, v);
        if (v[CB_FLAG] !== 1'b1) begin
            chk(8'h00, 8'h01);
            tally_and_finish();
        end
        rd(OFS_STATUS, v);
        chk(v & STATUS_MASK, code);
    endtask
    task automatic service(input logic [7:0] c);
        wr(OFS_CTRL, c);
        rd(OFS_STATUS, v);
        chk(v & STATUS_MASK, ST_NONE);
    endtask
    always @(posedge hang) begin
        chk(8'h00, 8'h01);
        tally_and_finish();
    end

    initial begin
        srst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        arb_lost = 1'b0;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            rd(rst_addr[k], v);
            chk(v, rst_val[k]);
        end
        seed = lfsr(seed);
        wr(OFS_STATUS, {6'h00, seed[1:0]});
        rd(OFS_STATUS, v);
        chk(v, ST_NONE | {6'h00, seed[1:0]});
        own = (seed[14:8] == 7'h00) ? 7'h2D : seed[14:8];
        wr(OFS_CTRL, 8'h44);
        // own address then broadcast: one acked byte, one nacked byte
        for (int bc = 0; bc < 2; bc++) begin
            wr(OFS_ADDR, {own, bc[0]});
            u_mst.start();
            u_mst.send(bc ? 8'h00 : {own, 1'b0}, ack);
            chk({7'h00, ack}, 8'h01);
            expect_code(rx_code(bc[0], 0));
            for (int s = 1; s < 3; s++) begin
                service(s == 1 ? 8'hC4 : 8'h84);
                seed = lfsr(seed);
                u_mst.send(seed[7:0], ack);
                chk({7'h00, ack}, s == 1 ? 8'h01 : 8'h00);
                expect_code(rx_code(bc[0], s));
                rd(OFS_DATA, v);
                chk(v, seed[7:0]);
            end
            service(8'hC4);
            u_mst.stop();
        end
        // stop while addressed, then recognition under each ack setting
        wr(OFS_ADDR, {own, 1'b0});
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CTRL, 8'h44);
            u_mst.start();
            u_mst.send({own, 1'b0}, ack);
            expect_code(8'h60);
            service(8'hC4);
            u_mst.stop();
            expect_code(8'hA0);
            service(m ? 8'hC4 : 8'h84);
            u_mst.start();
            u_mst.send(8'h00, ack);
            chk({7'h00, ack}, 8'h00);
            u_mst.start();
            u_mst.send({own, 1'b0}, ack);
            chk({7'h00, ack}, {7'h00, m[0]});
            if (m == 1) begin
                expect_code(8'h60);
                service(8'hC4);
            end
            u_mst.stop();
        end
        expect_code(8'hA0);
        service(8'hE4);
        expect_code(8'h08);
        chk({6'h00, scl_i, sda_i}, 8'h00);
        service(8'hE4);
        expect_code(8'h10);
        service(8'hD4);
        chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
        // lost arbitration, then addressed by own address or broadcast
        wr(OFS_ADDR, {own, 1'b1});
        for (int bc = 0; bc < 2; bc++) begin
            @(posedge ref_clk);
            arb_lost <= 1'b1;
            @(posedge ref_clk);
            arb_lost <= 1'b0;
            u_mst.start();
            u_mst.send(bc ? 8'h00 : {own, 1'b0}, ack);
            expect_code(rx_code(bc[0], 3));
            service(8'hC4);
            u_mst.start();
            expect_code(8'hA0);
            service(8'hC4);
            u_mst.stop();
        end
        // START in the middle of an address byte
        u_mst.start();
        for (int b = 0; b < 3; b++) u_mst.put_bit(own[6 - b], ack);
        u_mst.start();
        expect_code(8'h00);
        service(8'hD4);
        rd(OFS_CTRL, v);
        chk(v, 8'h44);
        chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
        u_mst.stop();
        tally_and_finish();
    end
endmodule

bind tws_slave_rx tws_rx_checker u_chk (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arb_lost(arb_lost),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

// [test/tws_master_model.sv]
/*
 * Bit-level bus master on the far side of the two-wire lines.
 * Assumes the testbench resolves the open-drain lines with a pull-up.
 */
`timescale 1ns/1ns
module tws_master_model (
    // resolved lines
    input wire logic scl,
    input wire logic sda,
    // open-drain drive, 0 pulls low
    output logic m_scl,
    output logic m_sda,
    // clock stretch lasted too long
    output logic hang
);
    initial begin
        m_scl = 1'b1;
        m_sda = 1'b1;
        hang = 1'b0;
    end
    // release clock and wait out a slave that stretches it
    task automatic release_scl();
        int i;
        m_scl = 1'b1;
        for (i = 0; i < 2000 && scl !== 1'b1; i++) #10;
        if (scl !== 1'b1) hang = 1'b1;
    endtask
    // also a repeated START, so a combined transfer stays whole
    task automatic start();
        #13 m_sda = 1'b1;
        #100 release_scl();
        #200 m_sda = 1'b0;
        #200 m_scl = 1'b0;
    endtask
    task automatic put_bit(input logic b, output logic r);
        #50 m_sda = b;
        #150 release_scl();
        #100 r = sda;
        #100 m_scl = 1'b0;
    endtask
    // msb first, then the acknowledge slot
    task automatic send(input logic [7:0] dat, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(dat[i], r);
        put_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic stop();
        #50 m_sda = 1'b0;
        #150 release_scl();
        #200 m_sda = 1'b1;
        #200;
    endtask
endmodule

// [test/tws_rx_checker.sv]
/*
 * Concurrent checks on the slave receiver ports.
 * Assumes one clock domain and a bind from the testbench top file.
 */
`timescale 1ns/1ns
module tws_rx_checker
    import tws_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // master logic
    input wire logic arb_lost,
    // open-drain lines
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire ctrl_wr = reg_wr && reg_addr == OFS_CTRL;
    wire mapped = reg_addr >= OFS_BITRATE && reg_addr <= OFS_CTRL;
    sequence s_status_rd;
        reg_rd && reg_addr == OFS_STATUS;
    endsequence
    sequence s_service;
        ctrl_wr && reg_wdata[CB_FLAG] && !reg_wdata[CB_BEGIN];
    endsequence
    sequence s_recover;
        ctrl_wr && reg_wdata[CB_FLAG] && reg_wdata[CB_HALT];
    endsequence
    sequence s_scl_high;
        scl_i [*3];
    endsequence
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside an answer");
    a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped offset read not zero");
    a_status_spare: assert property (s_status_rd |=> reg_rdata[2] == 1'b0)
        else $error("status spare bit set");
    a_status_known: assert property (s_status_rd |=> reg_rdata[7:3] inside {5'h1F, 5'h00, 5'h01,
        5'h02, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14})
        else $error("status code outside the known set");
    a_od_value: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("open-drain data value not zero");
    a_hold_until_wr: assert property (!scl_oe_n && !ctrl_wr |=> !scl_oe_n)
        else $error("clock hold dropped without a control write");
    a_service_frees: assert property (!scl_oe_n ##0 s_service |-> ##[1:3] scl_oe_n)
        else $error("clock not released after service");
    a_recover_frees: assert property (s_recover |-> ##[1:3] (scl_oe_n && sda_oe_n))
        else $error("lines not released after recovery");
    a_no_stop: assert property (s_scl_high |-> !$rose(sda_oe_n))
        else $error("data released while clock high");
endmodule

// [verilog/tws_line_sync.sv]
/*
 * Two-flop synchronisers for the clock and data lines, with edge,
 * START and STOP detection on the synchronised levels.
 * Assumes the lines are asynchronous to ref_clk.
 */
`timescale 1ns/1ns
module tws_line_sync
    import tws_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // raw line levels
    input wire logic scl_i,
    input wire logic sda_i,
    // synchronised levels and events
    output logic scl_s,
    output logic sda_s,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_det,
    output logic stop_det
);
    logic scl_m_r;
    logic sda_m_r;
    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scl_m_r <= 1'b1;
            sda_m_r <= 1'b1;
            scl_s <= 1'b1;
            sda_s <= 1'b1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_m_r <= scl_i;
            sda_m_r <= sda_i;
            scl_s <= scl_m_r;
            sda_s <= sda_m_r;
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    // data moving while the clock stays high marks START or STOP
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
endmodule

// [verilog/tws_pkg.sv]
/*
 * Shared constants for the two-wire slave receiver: register offsets,
 * reset values, control bit positions, status codes, timing and states.
 * Assumes a 20 MHz ref_clk and an 8-bit register port.
 */
package tws_pkg;
    // register offsets
    localparam logic [7:0] OFS_BITRATE = 8'hB8;
    localparam logic [7:0] OFS_STATUS = 8'hB9;
    localparam logic [7:0] OFS_ADDR = 8'hBA;
    localparam logic [7:0] OFS_DATA = 8'hBB;
    localparam logic [7:0] OFS_CTRL = 8'hBC;
    // reset values
    localparam logic [7:0] RST_BITRATE = 8'h00;
    localparam logic [7:0] RST_ADDR = 8'hFE;
    localparam logic [7:0] RST_DATA = 8'hFF;
    localparam logic [1:0] RST_PRESC = 2'h0;
    // control register bit positions
    localparam int CB_FLAG = 7;
    localparam int CB_ACK = 6;
    localparam int CB_BEGIN = 5;
    localparam int CB_HALT = 4;
    localparam int CB_WCOL = 3;
    localparam int CB_EN = 2;
    localparam int CB_IE = 0;
    // address register fields
    localparam int AB_GCE = 0;
    localparam logic [6:0] BROADCAST_ADDR = 7'h00;
    // status codes
    localparam logic [7:0] ST_NONE = 8'hF8;
    localparam logic [7:0] ST_BUS_ERR = 8'h00;
    localparam logic [7:0] ST_START = 8'h08;
    localparam logic [7:0] ST_RSTART = 8'h10;
    localparam logic [7:0] ST_SLA_W = 8'h60;
    localparam logic [7:0] ST_ARB_SLA = 8'h68;
    localparam logic [7:0] ST_GC = 8'h70;
    localparam logic [7:0] ST_ARB_GC = 8'h78;
    localparam logic [7:0] ST_DATA_ACK = 8'h80;
    localparam logic [7:0] ST_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_GC_ACK = 8'h90;
    localparam logic [7:0] ST_GC_NACK = 8'h98;
    localparam logic [7:0] ST_STOP_RS = 8'hA0;
    localparam logic [7:0] STATUS_MASK = 8'hF8;
    // bit counting
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_LEGAL_BIT = 4'h1;
    // timing
    localparam int CLK_NS = 50;
    localparam int T_BUF_NS = 4700;
    localparam int T_HDSTA_NS = 4000;
    localparam logic [7:0] BUF_CYC = 8'((T_BUF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] HDSTA_CYC = 8'((T_HDSTA_NS + CLK_NS - 1) / CLK_NS);
    // slave receiver states
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_ADDR = 7'h02,
        S_AACK = 7'h04,
        S_DATA = 7'h08,
        S_DACK = 7'h10,
        S_HOLD = 7'h20,
        S_WAIT = 7'h40
    } tws_state_t;
    // start generator states
    typedef enum logic [2:0] {
        G_IDLE = 3'h1,
        G_SETUP = 3'h2,
        G_START = 3'h4
    } tws_gen_t;
endpackage

// [verilog/tws_slave_rx.sv]
/*
 * Two-wire slave receiver with status codes, bus error recovery and a
 * START generator that keeps bus ownership over repeated STARTs.
 * Assumes a 20 MHz ref_clk, open-drain lines resolved outside, and
 * master-transmit logic on the same clock reporting lost arbitration.
 */
`timescale 1ns/1ns
module tws_slave_rx
    import tws_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // master logic on the same clock
    input wire logic arb_lost,
    // open-drain lines, enable low drives low
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    tws_line_sync u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    function automatic logic is_gc_code(input logic [7:0] code);
        is_gc_code = (code == ST_GC) || (code == ST_ARB_GC) || (code == ST_GC_ACK);
    endfunction

    // registers
    logic [7:0] bitrate_r;
    logic [1:0] presc_r;
    logic [7:0] addr_r;
    logic [7:0] data_r;
    logic flag_r;
    logic ack_en_r;
    logic begin_r;
    logic halt_r;
    logic wcol_r;
    logic en_r;
    logic ie_r;
    logic [7:0] code_r;
    logic busy_r;
    logic owned_r;
    logic arb_r;
    logic [7:0] rd_data_r;
    // receiver
    tws_state_t state_r;
    tws_state_t state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic drive_ack_r;
    logic drive_ack_nxt;
    logic rx_set;
    logic [7:0] rx_code;
    logic load_data;
    // generator
    tws_gen_t gen_r;
    tws_gen_t gen_nxt;
    logic [7:0] tmr_r;
    logic [7:0] tmr_nxt;
    logic gen_sda_low;
    logic gen_done;
    logic scl_hold_r;
    logic scl_low_nxt;
    logic sda_low_nxt;

    // register decode
    wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    wire wr_addr = reg_wr && (reg_addr == OFS_ADDR);
    wire wr_data = reg_wr && (reg_addr == OFS_DATA);
    wire wr_status = reg_wr && (reg_addr == OFS_STATUS);
    wire wr_bitrate = reg_wr && (reg_addr == OFS_BITRATE);
    wire service = wr_ctrl && reg_wdata[CB_FLAG] && flag_r;
    wire recover = service && reg_wdata[CB_HALT];
    wire ack_now = wr_ctrl ? reg_wdata[CB_ACK] : ack_en_r;
    wire [7:0] status_rd = (flag_r ? code_r : ST_NONE) & STATUS_MASK;
    wire [7:0] ctrl_rd = {flag_r, ack_en_r, begin_r, halt_r, wcol_r, en_r, 1'b0, ie_r};
    wire [7:0] rd_sel = (reg_addr == OFS_STATUS) ? (status_rd | {6'h00, presc_r}) :
                        (reg_addr == OFS_CTRL) ? ctrl_rd :
                        (reg_addr == OFS_ADDR) ? addr_r :
                        (reg_addr == OFS_DATA) ? data_r :
                        (reg_addr == OFS_BITRATE) ? bitrate_r : 8'h00;
    // address match, only with acknowledge enabled
    wire own_hit = ack_en_r && (shift_r[7:1] == addr_r[7:1]) && !shift_r[0];
    wire gc_hit = ack_en_r && addr_r[AB_GCE] && (shift_r[7:1] == BROADCAST_ADDR);
    wire early_bit = (cnt_r <= LAST_LEGAL_BIT);
    wire flag_set = rx_set || gen_done;
    wire [7:0] set_code = rx_set ? rx_code : (owned_r ? ST_RSTART : ST_START);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        drive_ack_nxt = drive_ack_r;
        rx_set = 1'b0;
        rx_code = ST_NONE;
        load_data = 1'b0;
        case (state_r)
            S_IDLE: begin
                // the START that this block drives itself opens no address phase
                if (start_det && en_r && !owned_r && gen_r != G_START) begin
                    state_nxt = S_ADDR;
                    cnt_nxt = 4'h0;
                end
            end
            S_ADDR: begin
                if ((start_det || stop_det) && !early_bit) begin
                    rx_set = 1'b1;
                    rx_code = ST_BUS_ERR;
                    state_nxt = S_WAIT;
                end else if (start_det) begin
                    cnt_nxt = 4'h0;
                end else if (stop_det) begin
                    state_nxt = S_IDLE;
                end else if (scl_rise) begin
                    shift_nxt = {shift_r[6:0], sda_s};
                    cnt_nxt = cnt_r + 4'h1;
                end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
                    state_nxt = (own_hit || gc_hit) ? S_AACK : S_IDLE;
                    drive_ack_nxt = own_hit || gc_hit;
                end
            end
            S_AACK, S_DACK: begin
                if (start_det || stop_det) begin
                    rx_set = 1'b1;
                    rx_code = ST_BUS_ERR;
                    drive_ack_nxt = 1'b0;
                    state_nxt = S_WAIT;
                end else if (scl_fall) begin
                    rx_set = 1'b1;
                    drive_ack_nxt = 1'b0;
                    if (state_r == S_AACK) begin
                        state_nxt = S_HOLD;
                        if (own_hit) begin
                            rx_code = arb_r ? ST_ARB_SLA : ST_SLA_W;
                        end else begin
                            rx_code = arb_r ? ST_ARB_GC : ST_GC;
                        end
                    end else begin
                        state_nxt = drive_ack_r ? S_HOLD : S_WAIT;
                        if (is_gc_code(code_r)) begin
                            rx_code = drive_ack_r ? ST_GC_ACK : ST_GC_NACK;
                        end else begin
                            rx_code = drive_ack_r ? ST_DATA_ACK : ST_DATA_NACK;
                        end
                    end
                end
            end
            S_DATA: begin
                if ((start_det || stop_det) && early_bit) begin
                    rx_set = 1'b1;
                    rx_code = ST_STOP_RS;
                    state_nxt = S_WAIT;
                end else if (start_det || stop_det) begin
                    rx_set = 1'b1;
                    rx_code = ST_BUS_ERR;
                    state_nxt = S_WAIT;
                end else if (scl_rise) begin
                    shift_nxt = {shift_r[6:0], sda_s};
                    cnt_nxt = cnt_r + 4'h1;
                end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
                    load_data = 1'b1;
                    drive_ack_nxt = ack_en_r;
                    state_nxt = S_DACK;
                end
            end
            S_HOLD: begin
                if (service) begin
                    state_nxt = recover ? S_IDLE : S_DATA;
                    cnt_nxt = 4'h0;
                end
            end
            S_WAIT: begin
                // after A0, a nacked byte or a bus error: not addressed
                if (service) begin
                    state_nxt = S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        if (!en_r) begin
            state_nxt = S_IDLE;
            drive_ack_nxt = 1'b0;
        end
    end

    // START generator: waits for a free bus, or its own bus for a restart
    always_comb begin
        gen_nxt = gen_r;
        tmr_nxt = tmr_r;
        gen_sda_low = 1'b0;
        gen_done = 1'b0;
        case (gen_r)
            G_IDLE: begin
                if (begin_r && en_r && !flag_r && state_r == S_IDLE && (!busy_r || owned_r)) begin
                    gen_nxt = G_SETUP;
                    tmr_nxt = BUF_CYC;
                end
            end
            G_SETUP: begin
                if (!scl_s || !sda_s || (busy_r && !owned_r)) begin
                    tmr_nxt = BUF_CYC;
                end else if (tmr_r == 8'h00) begin
                    gen_nxt = G_START;
                    tmr_nxt = HDSTA_CYC;
                end else begin
                    tmr_nxt = tmr_r - 8'h01;
                end
            end
            G_START: begin
                gen_sda_low = 1'b1;
                if (tmr_r == 8'h00) begin
                    gen_done = !rx_set;
                    gen_nxt = rx_set ? G_IDLE : gen_r;
                    if (!rx_set) begin
                        gen_nxt = G_IDLE;
                    end
                end else begin
                    tmr_nxt = tmr_r - 8'h01;
                end
            end
            default: begin
                gen_nxt = G_IDLE;
            end
        endcase
        if (!en_r || recover) begin
            gen_nxt = G_IDLE;
        end
    end

    // stretch the clock while software services an address match or an acked data byte
    assign scl_low_nxt = ((state_nxt == S_HOLD) && flag_r && !service) || (state_nxt == S_HOLD && rx_set)
                         || (gen_done || (scl_hold_r && owned_r && flag_r && !service));
    // data stays low under the held clock after an own START, so no STOP can appear
    assign sda_low_nxt = drive_ack_nxt || (gen_nxt == G_START) || (gen_sda_low && !gen_done)
                         || gen_done || (scl_hold_r && owned_r && flag_r && !service);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= S_IDLE;
            gen_r <= G_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            drive_ack_r <= 1'b0;
            tmr_r <= 8'h00;
            scl_hold_r <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            gen_r <= gen_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            drive_ack_r <= drive_ack_nxt;
            tmr_r <= tmr_nxt;
            scl_hold_r <= scl_low_nxt && !recover;
            scl_oe_n <= !(scl_low_nxt && !recover);
            sda_oe_n <= !(sda_low_nxt && !recover);
        end
    end

    // flag and status: a hardware set wins over a software clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flag_r <= 1'b0;
            code_r <= ST_NONE;
        end else if (flag_set) begin
            flag_r <= 1'b1;
            code_r <= set_code;
        end else if (service) begin
            flag_r <= 1'b0;
        end
    end

    // control bits
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_en_r <= 1'b0;
            begin_r <= 1'b0;
            halt_r <= 1'b0;
            wcol_r <= 1'b0;
            en_r <= 1'b0;
            ie_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ack_en_r <= reg_wdata[CB_ACK];
                en_r <= reg_wdata[CB_EN];
                ie_r <= reg_wdata[CB_IE];
                wcol_r <= reg_wdata[CB_WCOL];
                begin_r <= reg_wdata[CB_BEGIN];
                halt_r <= reg_wdata[CB_HALT] && !recover;
            end else if (gen_done) begin
                begin_r <= 1'b0;
            end
            if (wr_data && !flag_r) begin
                wcol_r <= 1'b1;
            end
        end
    end

    // bus state, ownership and other registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_r <= 1'b0;
            owned_r <= 1'b0;
            arb_r <= 1'b0;
            addr_r <= RST_ADDR;
            data_r <= RST_DATA;
            bitrate_r <= RST_BITRATE;
            presc_r <= RST_PRESC;
            rd_data_r <= 8'h00;
        end else begin
            busy_r <= (busy_r || start_det) && !stop_det;
            // a repeated START leaves ownership in place
            owned_r <= (owned_r || gen_done) && !stop_det && !recover && en_r;
            // lost arbitration is kept until the next address phase ends, matched or not
            arb_r <= (arb_r || arb_lost) && !(state_r == S_AACK && scl_fall)
                     && !(state_r == S_ADDR && state_nxt == S_IDLE);
            if (wr_addr) begin
                addr_r <= reg_wdata;
            end
            if (load_data) begin
                data_r <= shift_r;
            end else if (wr_data && flag_r) begin
                data_r <= reg_wdata;
            end
            if (wr_bitrate) begin
                bitrate_r <= reg_wdata;
            end
            if (wr_status) begin
                presc_r <= reg_wdata[1:0];
            end
            rd_data_r <= reg_rd ? rd_sel : 8'h00;
        end
    end

    assign reg_rdata = rd_data_r;
endmodule
